//--- pkg/pmtr_pkg.sv
// shared constants and types of the program memory access unit
package pmtr_pkg;
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int WORDS = 4096;
  localparam logic [11:0] RST_VEC = 12'h000;
  localparam logic [3:0] LAST_PAGE = 4'hF;
  // register offsets
  localparam logic [2:0] OFS_TBLP = 3'h0;
  localparam logic [2:0] OFS_TBHP = 3'h1;
  localparam logic [2:0] OFS_TABLE_HIGH_BYTE_HOLDER = 3'h2;
  localparam logic [2:0] OFS_PCL = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PROG = 1;
  // one instruction cycle is four clocks (T1..T4)
  localparam logic [1:0] DIV_LAST = 2'h3;
  // serial frame: bit 0 command, bits 1..12 address, bits 13..28 data
  localparam logic [4:0] SER_ADDR_LAST = 5'h0C;
  localparam logic [4:0] SER_LAST = 5'h1C;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_TBL   = 3'b010,
    ST_PROG  = 3'b100
  } pmtr_st_t;
  typedef struct packed {
    logic       req;
    logic       ext;
    logic       last;
    logic [8:0] dest;
  } pmtr_tcmd_t;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } pmtr_dm_t;
  typedef struct packed {
    pmtr_st_t    st;
    logic [1:0]  div;
    logic [11:0] pc;
    logic [7:0]  tblp;
    logic [7:0]  tbhp;
    logic [7:0]  table_high_byte_holder;
    logic [15:0] instr;
    logic        ivalid;
    logic        dm_we;
    pmtr_dm_t    dm;
    logic        ext;
    logic        last;
    logic [8:0]  dest;
    logic [7:0]  rdata;
    logic        sclk_q;
    logic [4:0]  sbit;
    logic        sread;
    logic [11:0] saddr;
    logic [15:0] sdata;
    logic        sdo;
    logic        soe_n;
    logic        mwe;
    logic [11:0] mwaddr;
    logic [15:0] mwdata;
  } pmtr_state_t;
endpackage

//--- hw/pmtr_top.sv
// program memory: fetch, table read, serial programming
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - program memory holds 4096 words of 16 bits.
// - instructions are fetched at the word address in the program counter.
// - reset loads 0000H into the program counter.
// - table reads use their own pointer, independent of the program counter.
// - the table address joins the low and high table pointer registers; last-page forms put page F above the low pointer.
// - a table read writes the low byte of the word to the named data location.
// - the same table read puts the high byte in the table high byte holder.
// - ordinary forms reach sector 0 only, extended forms reach any sector.
// - every table instruction takes two instruction cycles.
// - software can read and write the table high byte holder.
// - programming moves data both ways on one serial data line clocked by the programmer.
// - only the low byte of the program counter is readable and writable by software.
module pmtr_top #(
  parameter int WORDS = pmtr_pkg::WORDS
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire pmtr_pkg::pmtr_tcmd_t tbl_cmd,
  input  wire logic               pc_load,
  input  wire logic [11:0]        pc_load_addr,
  output logic [15:0]             instr,
  output logic                    instr_valid,
  output logic [11:0]             pc,
  output logic                    dm_we,
  output pmtr_pkg::pmtr_dm_t      dm_wr,
  output logic                    busy,
  input  wire logic               prog_mode,
  input  wire logic               programming_serial_clock,
  input  wire logic               programming_serial_data_in,
  output logic                    programming_serial_data_out,
  output logic                    programming_serial_data_oe_n
);
  pmtr_pkg::pmtr_state_t s_r;
  pmtr_pkg::pmtr_state_t s_nxt;
  logic [15:0] mem [WORDS];
  logic        tick;
  logic        srise;
  logic [11:0] taddr;
  logic [15:0] tword;
  logic [11:0] sa_full;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  assign tick = (s_r.div == pmtr_pkg::DIV_LAST);
  assign srise = programming_serial_clock & ~s_r.sclk_q;
  // last-page forms ignore the high pointer
  assign taddr = s_r.last ? {pmtr_pkg::LAST_PAGE, s_r.tblp}
                          : {s_r.tbhp[3:0], s_r.tblp};
  assign tword = mem[taddr];
  assign sa_full = {s_r.saddr[10:0], programming_serial_data_in};

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.div = s_r.div + 2'h1;
    s_nxt.ivalid = 1'b0;
    s_nxt.dm_we = 1'b0;
    s_nxt.mwe = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.sclk_q = programming_serial_clock;
    case (s_r.st)
      pmtr_pkg::ST_FETCH:
      begin
        if (tick)
        begin
          s_nxt.instr = mem[s_r.pc];
          s_nxt.ivalid = 1'b1;
          s_nxt.pc = pc_load ? pc_load_addr : s_r.pc + 12'h001;
          if (tbl_cmd.req)
          begin
            // first cycle of the table instruction
            s_nxt.st = pmtr_pkg::ST_TBL;
            s_nxt.ext = tbl_cmd.ext;
            s_nxt.last = tbl_cmd.last;
            s_nxt.dest = tbl_cmd.dest;
          end
        end
      end
      pmtr_pkg::ST_TBL:
      begin
        if (tick)
        begin
          // port belongs to the table word, no fetch this cycle
          s_nxt.st = pmtr_pkg::ST_FETCH;
          s_nxt.dm_we = 1'b1;
          s_nxt.dm.data = tword[7:0];
          // ordinary forms cannot leave sector 0
          s_nxt.dm.addr = s_r.ext ? s_r.dest : {1'b0, s_r.dest[7:0]};
          s_nxt.table_high_byte_holder = tword[15:8];
        end
      end
      pmtr_pkg::ST_PROG:
      begin
        if (srise)
        begin
          s_nxt.sbit = (s_r.sbit == pmtr_pkg::SER_LAST) ? 5'h00 : s_r.sbit + 5'h01;
          if (s_r.sbit == 5'h00)
          begin
            s_nxt.sread = programming_serial_data_in;
          end
          else if (s_r.sbit <= pmtr_pkg::SER_ADDR_LAST)
          begin
            s_nxt.saddr = sa_full;
            if (s_r.sbit == pmtr_pkg::SER_ADDR_LAST && s_r.sread)
            begin
              // upload: device takes the shared line
              s_nxt.sdata = mem[sa_full];
              s_nxt.sdo = mem[sa_full][15];
              s_nxt.soe_n = 1'b0;
            end
          end
          else if (s_r.sread)
          begin
            s_nxt.sdata = {s_r.sdata[14:0], 1'b0};
            s_nxt.sdo = s_r.sdata[14];
            if (s_r.sbit == pmtr_pkg::SER_LAST)
            begin
              s_nxt.soe_n = 1'b1;
            end
          end
          else
          begin
            s_nxt.sdata = {s_r.sdata[14:0], programming_serial_data_in};
            if (s_r.sbit == pmtr_pkg::SER_LAST)
            begin
              s_nxt.mwe = 1'b1;
              s_nxt.mwaddr = s_r.saddr;
              s_nxt.mwdata = {s_r.sdata[14:0], programming_serial_data_in};
            end
          end
        end
      end
      default:
      begin
        s_nxt.st = pmtr_pkg::ST_FETCH;
      end
    endcase
    // programming owns the array; core and serial state restart around it
    if (prog_mode)
    begin
      s_nxt.st = pmtr_pkg::ST_PROG;
    end
    else if (s_r.st == pmtr_pkg::ST_PROG)
    begin
      s_nxt.st = pmtr_pkg::ST_FETCH;
      s_nxt.sbit = 5'h00;
      s_nxt.soe_n = 1'b1;
      s_nxt.div = 2'h0;
    end
    if (reg_wr)
    begin
      if (hit(reg_addr, pmtr_pkg::OFS_TBLP))
      begin
        s_nxt.tblp = reg_wdata;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_TBHP))
      begin
        s_nxt.tbhp = reg_wdata;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER))
      begin
        s_nxt.table_high_byte_holder = reg_wdata;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_PCL))
      begin
        // short jump inside the current 256-word page
        s_nxt.pc = {s_r.pc[11:8], reg_wdata};
      end
    end
    if (reg_rd)
    begin
      if (hit(reg_addr, pmtr_pkg::OFS_TBLP))
      begin
        s_nxt.rdata = s_r.tblp;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_TBHP))
      begin
        s_nxt.rdata = s_r.tbhp;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER))
      begin
        s_nxt.rdata = s_r.table_high_byte_holder;
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_PCL))
      begin
        s_nxt.rdata = s_r.pc[7:0];
      end
      else if (hit(reg_addr, pmtr_pkg::OFS_STAT))
      begin
        s_nxt.rdata[pmtr_pkg::STAT_BUSY] = (s_r.st == pmtr_pkg::ST_TBL);
        s_nxt.rdata[pmtr_pkg::STAT_PROG] = (s_r.st == pmtr_pkg::ST_PROG);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.st <= pmtr_pkg::ST_FETCH;
      s_r.pc <= pmtr_pkg::RST_VEC;
      s_r.soe_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // flash array, written only by the serial programmer
  always_ff @(posedge clock)
  begin
    if (s_r.mwe)
    begin
      mem[s_r.mwaddr] <= s_r.mwdata;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign instr = s_r.instr;
  assign instr_valid = s_r.ivalid;
  assign pc = s_r.pc;
  assign dm_we = s_r.dm_we;
  assign dm_wr = s_r.dm;
  assign busy = (s_r.st != pmtr_pkg::ST_FETCH);
  assign programming_serial_data_out = s_r.sdo;
  assign programming_serial_data_oe_n = s_r.soe_n;

  logic fetch_go;
  logic tbl_go;
  logic pcl_wr;
  assign fetch_go = tick && s_r.st == pmtr_pkg::ST_FETCH && !prog_mode && !tbl_cmd.req && !reg_wr;
  assign tbl_go = tick && s_r.st == pmtr_pkg::ST_FETCH && !prog_mode && tbl_cmd.req;
  assign pcl_wr = reg_wr && hit(reg_addr, pmtr_pkg::OFS_PCL);

  sequence tbl_access;
    // the accept tick still delivers its own fetch in the first cycle
    s_r.st == pmtr_pkg::ST_TBL ##1 (s_r.st == pmtr_pkg::ST_TBL && !s_r.ivalid)[*3];
  endsequence
  sequence tbl_done;
    s_r.dm_we && s_r.st == pmtr_pkg::ST_FETCH;
  endsequence

  chk_reset_vector: assert property (@(posedge clock) sys_rst |=> s_r.pc == 12'h000)
    else $error("pc not at reset vector");
  chk_fetch_word: assert property (@(posedge clock) disable iff (sys_rst)
    fetch_go |=> s_r.ivalid && s_r.instr == $past(mem[s_r.pc]))
    else $error("fetched word not from pc address");
  chk_pc_step: assert property (@(posedge clock) disable iff (sys_rst)
    fetch_go && !pc_load |=> s_r.pc == $past(s_r.pc) + 12'h001)
    else $error("pc did not advance by one");
  chk_tbl_two_cycles: assert property (@(posedge clock) disable iff (sys_rst || prog_mode)
    tbl_go |=> tbl_access ##1 tbl_done)
    else $error("table read not two instruction cycles");
  chk_tbl_low_byte: assert property (@(posedge clock) disable iff (sys_rst || prog_mode)
    tick && s_r.st == pmtr_pkg::ST_TBL |=> s_r.dm.data == $past(tword[7:0]))
    else $error("table low byte wrong");
  chk_tbl_high_byte: assert property (@(posedge clock) disable iff (sys_rst || prog_mode)
    tick && s_r.st == pmtr_pkg::ST_TBL && !reg_wr |=> s_r.table_high_byte_holder == $past(tword[15:8]))
    else $error("table high byte wrong");
  chk_tbl_address: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.st == pmtr_pkg::ST_TBL && !s_r.last |-> taddr[11:8] == s_r.tbhp[3:0] && taddr[7:0] == s_r.tblp)
    else $error("table address not from pointers");
  chk_sector_zero: assert property (@(posedge clock) disable iff (sys_rst)
    s_r.dm_we && !s_r.ext |-> s_r.dm.addr[8] == 1'b0)
    else $error("ordinary table read left sector 0");
  chk_pcl_write: assert property (@(posedge clock) disable iff (sys_rst)
    pcl_wr && !prog_mode |=> s_r.pc == {$past(s_r.pc[11:8]), $past(reg_wdata)})
    else $error("pc low byte write wrong");
  chk_holder_rw: assert property (@(posedge clock) disable iff (sys_rst)
    reg_wr && hit(reg_addr, pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER) ##1 reg_rd && hit(reg_addr, pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER)
    && !(tick && s_r.st == pmtr_pkg::ST_TBL) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("holder readback wrong");
endmodule

//--- verif/pmtr_programmer.sv
// serial programmer model for the program memory programming port
`timescale 1ns/1ps
module pmtr_programmer (
  input  wire logic clock,
  input  wire logic line_in,
  output logic      sclk,
  output logic      drv,
  output logic      drv_en
);
  initial
  begin
    sclk = 1'b0;
    drv = 1'b0;
    drv_en = 1'b1;
  end
  // ==========================================
  // frame: command, 12 address bits, 16 data bits, msb first
  // clock stands low between frames; the programmer changes data only while it is low, the device one clock after the rising edge
  task automatic frame(input logic rd, input logic [11:0] addr, input logic [15:0] wdat, output logic [15:0] rdat);
    logic [28:0] bits;
    bits = {rd, addr, wdat};
    rdat = 16'h0000;
    for (int i = 28; i >= 0; i--)
    begin
      @(posedge clock);
      drv <= bits[i];
      drv_en <= !(rd && i < 16);
      repeat (4) @(posedge clock);
      if (rd && i < 16)
        rdat[i] = line_in;
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
    end
    @(posedge clock);
    drv_en <= 1'b1;
  endtask
endmodule

//--- verif/pmtr_bench.sv
// self-checking testbench of the program memory access unit
`timescale 1ns/1ps
module pmtr_bench;
  logic                 clock, sys_rst, reg_wr, reg_rd, pc_load, prog_mode;
  logic [2:0]           reg_addr;
  logic [7:0]           reg_wdata, reg_rdata, d, n;
  logic [11:0]          pc_load_addr, pc;
  logic [15:0]          instr, q;
  logic                 instr_valid, dm_we, busy, drv, drv_en, line_q;
  logic                 programming_serial_clock, programming_serial_data_in;
  logic                 programming_serial_data_out, programming_serial_data_oe_n;
  pmtr_pkg::pmtr_tcmd_t tbl_cmd;
  pmtr_pkg::pmtr_dm_t   dm_wr;
  int                   bad_count, compares;
  logic [7:0]           hp [4] = '{8'hA2, 8'h02, 8'h0F, 8'h00};
  logic                 ex [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic                 la [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [8:0]           de [4] = '{9'h1F5, 9'h044, 9'h1F5, 9'h1C3};
  logic [8:0]           ea [4] = '{9'h0F5, 9'h044, 9'h1F5, 9'h1C3};
  logic [7:0]           ed [4] = '{8'h71, 8'h2B, 8'h2B, 8'h2B};
  logic [7:0]           eh [4] = '{8'h9D, 8'h1A, 8'h1A, 8'h1A};
  logic [11:0]          pa [3] = '{12'h3A5, 12'hF06, 12'h206};
  logic [15:0]          pw [3] = '{16'hC35A, 16'h1A2B, 16'h9D71};

  initial clock = 1'b0;
  always #4 clock = ~clock;
  // released line shows the inverse of its last level
  assign programming_serial_data_in = !programming_serial_data_oe_n ? programming_serial_data_out
                                      : (drv_en ? drv : !line_q);
  always @(posedge clock) line_q <= programming_serial_data_in;

  pmtr_top u_pmtr_top (
    .clock,
    .sys_rst,
    .reg_addr,
    .reg_wdata,
    .reg_wr,
    .reg_rd,
    .reg_rdata,
    .tbl_cmd,
    .pc_load,
    .pc_load_addr,
    .instr,
    .instr_valid,
    .pc,
    .dm_we,
    .dm_wr,
    .busy,
    .prog_mode,
    .programming_serial_clock,
    .programming_serial_data_in,
    .programming_serial_data_out,
    .programming_serial_data_oe_n
  );
  pmtr_programmer u_pmtr_programmer (
    .clock   (clock),
    .line_in (programming_serial_data_in),
    .sclk    (programming_serial_clock),
    .drv     (drv),
    .drv_en  (drv_en)
  );
  // ==========================================
  // bus tasks and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the next fetch pulse, n counts the clocks
  task automatic wait_iv();
    n = 8'h00;
    do
    begin
      @(posedge clock);
      #1 n++;
    end while (instr_valid !== 1'b1 && n < 8'd20);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
  // ==========================================
  // tests
  initial
  begin
    {sys_rst, reg_wr, reg_rd, pc_load, prog_mode} = 5'b10000;
    {reg_addr, reg_wdata, pc_load_addr} = '0;
    tbl_cmd = '0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk({4'h0, pc}, {4'h0, pmtr_pkg::RST_VEC});
    wait_iv();
    chk({4'h0, pc}, 16'h0001);
    wait_iv();
    chk({8'h00, n}, 16'h0004);
    $display("test fetch done");
    @(posedge clock);
    prog_mode <= 1'b1;
    rd(pmtr_pkg::OFS_STAT, d);
    chk({8'h00, d}, 16'h0002);
    for (int i = 0; i < 3; i++)
      u_pmtr_programmer.frame(1'b0, pa[i], pw[i], q);
    u_pmtr_programmer.frame(1'b1, pa[0], 16'h0000, q);
    chk(q, pw[0]);
    chk({15'h0, programming_serial_data_oe_n}, 16'h0001);
    @(posedge clock);
    prog_mode <= 1'b0;
    $display("test programming done");
    @(posedge clock);
    pc_load <= 1'b1;
    pc_load_addr <= pa[0];
    wait_iv();
    chk({4'h0, pc}, {4'h0, pa[0]});
    @(posedge clock);
    pc_load <= 1'b0;
    wait_iv();
    chk(instr, pw[0]);
    wr(pmtr_pkg::OFS_PCL, 8'h40);
    rd(pmtr_pkg::OFS_PCL, d);
    chk({8'h00, d & 8'hFE}, 16'h0040);
    chk({12'h000, pc[11:8]}, 16'h0003);
    wr(pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER, 8'h5C);
    rd(pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER, d);
    chk({8'h00, d}, 16'h005C);
    rd(3'h7, d);
    chk({8'h00, d}, 16'h0000);
    // write then read back with no gap between the strobes
    @(posedge clock);
    reg_addr <= pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER;
    reg_wdata <= 8'hA7;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, 16'h00A7);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(pmtr_pkg::OFS_TBLP, 8'h06);
      wr(pmtr_pkg::OFS_TBHP, hp[i]);
      @(posedge clock);
      tbl_cmd <= '{req: 1'b1, ext: ex[i], last: la[i], dest: de[i]};
      n = 8'h00;
      do
      begin
        @(posedge clock);
        #1 n++;
      end while (busy !== 1'b1 && n < 8'd20);
      n = 8'h00;
      d = 8'h00;
      do
      begin
        @(posedge clock);
        tbl_cmd.req <= 1'b0;
        #1 n++;
        d = d + {7'h0, instr_valid === 1'b1};
      end while (dm_we !== 1'b1 && n < 8'd20);
      chk({8'h00, n}, 16'h0004);
      chk({8'h00, d}, 16'h0000);
      chk({7'h00, dm_wr.addr}, {7'h00, ea[i]});
      chk({8'h00, dm_wr.data}, {8'h00, ed[i]});
      rd(pmtr_pkg::OFS_TABLE_HIGH_BYTE_HOLDER, d);
      chk({8'h00, d}, {8'h00, eh[i]});
    end
    $display("test table reads done");
    tally_and_finish();
  end
endmodule
